// ### link_bist_map.vh
`ifndef LINK_BIST_MAP_VH
`define LINK_BIST_MAP_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFF_SELF_TEST_CONTROL 8'h00
`define OFF_PATTERN_SEQ_CTRL 8'h04
`define OFF_BUF_ONE_LOW 8'h08
`define OFF_LANE_MASK 8'h0C
`define OFF_LANE_INVERT 8'h10
`define OFF_BUF_TWO_LOW 8'h14
`define OFF_LANE_BUF_TWO 8'h18
`define OFF_BUF_UPPER 8'h1C
`define OFF_LANE_SCRAMBLE 8'h20
`define OFF_LANE_ERROR 8'h24

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ORDER_MSB 2
`define ORDER_LSB 0
`define BUF_CNT_MSB 9
`define BUF_CNT_LSB 3
`define TOG_SEL_MSB 12
`define TOG_SEL_LSB 10
`define TOG_CNT_MSB 19
`define TOG_CNT_LSB 13
`define CONST_VAL_BIT 20
`define CONST_LEN_MSB 25
`define CONST_LEN_LSB 21
`define SEQ_CTRL_MSB 25
`define RUN_BIT 0
`define ROT_EN_BIT 5
`define WIDTH_BIT 31
`define LANES 18
`define BUF_LOW_MSB 23

// ------------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------------
`define LANE_MASK_RESET 18'h3FFFF
`define BUF_ONE_RESET 40'h0000000000
`define BUF_TWO_RESET 40'h0000000000
`define ENGINE_WIDTH_16 1'b1
`define BUF_BITS 6'h28
`define UNIT_BITS 6'h18
`define LFSR_SEED 15'h7FFF
`define SRC_BUF 2'h0
`define SRC_TOG 2'h1
`define SRC_CONST 2'h2
`define SRC_NONE 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### link_bist_engine.v
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "link_bist_map.vh"
// Overview of operation
// - Order field picks six source sequences
// - Buffer repeats 0 to 127 per loop
// - Toggle select picks L/2 to L/24
// - Toggle pattern repeats 0 to 127
// - Constant bit drives zeros or ones
// - Constant length in 24-bit units
// - Buffer low registers hold bits 23:0
// - Shared register holds both buffers' 39:24
// - Common lane bit map; mask resets active
// - Masked lanes send zeros before scrambling, unchecked
// - Inversion bit inverts lane both ways
// - Rotate inversion left at loop end
// - Select bit chooses buffer two
// - Scramble bit scrambles and descrambles lane
// - Error flags per lane, write zeros clears
// - Reset values of all registers
// - Rotate enable bit in control register
// - Width bit reads 16-bit engine
module link_bist_engine (
	// Clock, reset and enable
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	// AXI4-Lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Link side
	input wire link_clk,
	input wire [17:0] rx_lane,
	output reg [17:0] tx_lane,
	output reg engine_active
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer b;
		begin
			merge_bytes = old_val;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
	endfunction

	function [1:0] source_at;
		input [2:0] order;
		input [1:0] step;
		begin
			case ({order, step})
				5'h00, 5'h04, 5'h09, 5'h0E: source_at = `SRC_BUF;
				5'h01, 5'h06, 5'h08, 5'h0C: source_at = `SRC_TOG;
				5'h02, 5'h05, 5'h0A, 5'h0D, 5'h10: source_at = `SRC_CONST;
				5'h11: source_at = `SRC_BUF;
				5'h12: source_at = `SRC_TOG;
				5'h14: source_at = `SRC_CONST;
				5'h15: source_at = `SRC_TOG;
				5'h16: source_at = `SRC_BUF;
				default: source_at = `SRC_NONE;
			endcase
		end
	endfunction

	function toggle_bit;
		input [2:0] sel;
		input [5:0] pos;
		begin
			case (sel)
				3'h1: toggle_bit = pos[0];
				3'h2: toggle_bit = pos[1];
				3'h3: toggle_bit = ((pos % 6'h06) >= 6'h03);
				3'h4: toggle_bit = pos[2];
				3'h6: toggle_bit = (pos >= 6'h0C);
				default: toggle_bit = 1'b0;
			endcase
		end
	endfunction

	function toggle_valid;
		input [2:0] sel;
		begin
			case (sel)
				3'h1, 3'h2, 3'h3, 3'h4, 3'h6: toggle_valid = 1'b1;
				default: toggle_valid = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg run_reg;
	reg rot_en_reg;
	reg [25:0] seq_ctrl_reg;
	reg [39:0] buf_one_reg;
	reg [39:0] buf_two_reg;
	reg [17:0] mask_reg;
	reg [17:0] invert_reg;
	reg [17:0] buf_sel_reg;
	reg [17:0] scramble_reg;
	reg [17:0] error_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	wire [2:0] order = seq_ctrl_reg[`ORDER_MSB:`ORDER_LSB];
	wire [6:0] buf_cnt = seq_ctrl_reg[`BUF_CNT_MSB:`BUF_CNT_LSB];
	wire [2:0] tog_sel = seq_ctrl_reg[`TOG_SEL_MSB:`TOG_SEL_LSB];
	wire [6:0] tog_cnt = seq_ctrl_reg[`TOG_CNT_MSB:`TOG_CNT_LSB];
	wire const_val = seq_ctrl_reg[`CONST_VAL_BIT];
	wire [4:0] const_len = seq_ctrl_reg[`CONST_LEN_MSB:`CONST_LEN_LSB];
	// ------------------------------------------------------------------
	// Link clock and receive synchronisers
	// ------------------------------------------------------------------
	reg lclk_s1_reg;
	reg lclk_s2_reg;
	reg lclk_s3_reg;
	reg [17:0] rx_s1_reg;
	reg [17:0] rx_s2_reg;
	wire bit_tick = lclk_s2_reg & ~lclk_s3_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			lclk_s1_reg <= 1'b0;
			lclk_s2_reg <= 1'b0;
			lclk_s3_reg <= 1'b0;
			rx_s1_reg <= 18'h00000;
			rx_s2_reg <= 18'h00000;
		end else if (clk_en) begin
			lclk_s1_reg <= link_clk;
			lclk_s2_reg <= lclk_s1_reg;
			lclk_s3_reg <= lclk_s2_reg;
			rx_s1_reg <= rx_lane;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	reg [1:0] step_reg;
	reg [5:0] pos_reg;
	reg [6:0] rep_reg;
	reg [14:0] lfsr_reg;
	reg loop_sent_reg;
	reg [1:0] cur_src;
	reg [6:0] cur_reps;
	reg [5:0] cur_unit;
	reg [17:0] expect_lanes;
	reg pat_bit;
	integer i;
	always @* begin
		cur_src = source_at(order, step_reg);
		cur_reps = 7'h00;
		cur_unit = `UNIT_BITS;
		case (cur_src)
			`SRC_BUF: begin
				cur_reps = buf_cnt;
				cur_unit = `BUF_BITS;
			end
			`SRC_TOG: cur_reps = toggle_valid(tog_sel) ? tog_cnt : 7'h00;
			`SRC_CONST: cur_reps = {2'h0, const_len};
			default: cur_reps = 7'h00;
		endcase
		expect_lanes = 18'h00000;
		pat_bit = 1'b0;
		for (i = 0; i < `LANES; i = i + 1) begin
			case (cur_src)
				`SRC_BUF: pat_bit = buf_sel_reg[i] ? buf_two_reg[pos_reg] :
					buf_one_reg[pos_reg];
				`SRC_TOG: pat_bit = toggle_bit(tog_sel, pos_reg);
				`SRC_CONST: pat_bit = const_val;
				default: pat_bit = 1'b0;
			endcase
			// Masked lanes carry zero before scrambling
			expect_lanes[i] = (mask_reg[i] & (pat_bit ^ invert_reg[i])) ^
				(scramble_reg[i] & lfsr_reg[i % 15]);
		end
	end
	wire src_empty = (cur_reps == 7'h00);
	wire unit_end = (pos_reg == cur_unit - 6'h01);
	wire rep_end = (rep_reg == cur_reps - 7'h01);
	wire step_done = src_empty | (bit_tick & unit_end & rep_end);
	wire loop_end = run_reg & step_done & (step_reg == 2'h2);
	// Idle loops with nothing sent never rotate, so reserved settings are harmless
	wire rotate_now = loop_end & rot_en_reg & (loop_sent_reg | bit_tick & ~src_empty);
	always @(posedge aclk) begin
		if (!aresetn) begin
			step_reg <= 2'h0;
			pos_reg <= 6'h00;
			rep_reg <= 7'h00;
			lfsr_reg <= `LFSR_SEED;
			loop_sent_reg <= 1'b0;
			tx_lane <= 18'h00000;
			engine_active <= 1'b0;
		end else if (clk_en) begin
			engine_active <= run_reg;
			if (!run_reg) begin
				step_reg <= 2'h0;
				pos_reg <= 6'h00;
				rep_reg <= 7'h00;
				lfsr_reg <= `LFSR_SEED;
				loop_sent_reg <= 1'b0;
				tx_lane <= 18'h00000;
			end else begin
				if (bit_tick & ~src_empty) begin
					tx_lane <= expect_lanes;
					lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
					loop_sent_reg <= 1'b1;
					pos_reg <= unit_end ? 6'h00 : pos_reg + 6'h01;
					if (unit_end)
						rep_reg <= rep_end ? 7'h00 : rep_reg + 7'h01;
				end
				if (step_done) begin
					pos_reg <= 6'h00;
					rep_reg <= 7'h00;
					if (step_reg == 2'h2) begin
						step_reg <= 2'h0;
						loop_sent_reg <= 1'b0;
					end else begin
						step_reg <= step_reg + 2'h1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Receive checker
	// ------------------------------------------------------------------
	wire [17:0] rx_fail = (run_reg & bit_tick & ~src_empty) ?
		(mask_reg & (rx_s2_reg ^ expect_lanes)) : 18'h00000;

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [31:0] wr_val = wdata_reg;
	reg wr_hit;
	reg [31:0] rd_val;
	reg rd_hit;
	always @* begin
		case (awaddr_reg)
			`OFF_SELF_TEST_CONTROL, `OFF_PATTERN_SEQ_CTRL, `OFF_BUF_ONE_LOW,
			`OFF_LANE_MASK, `OFF_LANE_INVERT, `OFF_BUF_TWO_LOW, `OFF_LANE_BUF_TWO,
			`OFF_BUF_UPPER, `OFF_LANE_SCRAMBLE, `OFF_LANE_ERROR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end
	always @* begin
		rd_hit = 1'b1;
		rd_val = 32'h00000000;
		case (s_axi_araddr)
			`OFF_SELF_TEST_CONTROL: begin
				rd_val[`WIDTH_BIT] = `ENGINE_WIDTH_16;
				rd_val[`ROT_EN_BIT] = rot_en_reg;
				rd_val[`RUN_BIT] = run_reg;
			end
			`OFF_PATTERN_SEQ_CTRL: rd_val = {6'h00, seq_ctrl_reg};
			`OFF_BUF_ONE_LOW: rd_val = {8'h00, buf_one_reg[23:0]};
			`OFF_LANE_MASK: rd_val = {14'h0000, mask_reg};
			`OFF_LANE_INVERT: rd_val = {14'h0000, invert_reg};
			`OFF_BUF_TWO_LOW: rd_val = {8'h00, buf_two_reg[23:0]};
			`OFF_LANE_BUF_TWO: rd_val = {14'h0000, buf_sel_reg};
			`OFF_BUF_UPPER: rd_val = {buf_two_reg[39:24], buf_one_reg[39:24]};
			`OFF_LANE_SCRAMBLE: rd_val = {14'h0000, scramble_reg};
			`OFF_LANE_ERROR: rd_val = {14'h0000, error_reg};
			default: rd_hit = 1'b0;
		endcase
	end
	wire [31:0] m_ctrl = merge_bytes({26'h0000000, rot_en_reg, 4'h0, run_reg}, wr_val, wstrb_reg);
	wire [31:0] m_seq = merge_bytes({6'h00, seq_ctrl_reg}, wr_val, wstrb_reg);
	wire [31:0] m_b1 = merge_bytes({8'h00, buf_one_reg[23:0]}, wr_val, wstrb_reg);
	wire [31:0] m_b2 = merge_bytes({8'h00, buf_two_reg[23:0]}, wr_val, wstrb_reg);
	wire [31:0] m_up = merge_bytes({buf_two_reg[39:24], buf_one_reg[39:24]}, wr_val, wstrb_reg);
	wire [31:0] m_mask = merge_bytes({14'h0000, mask_reg}, wr_val, wstrb_reg);
	wire [31:0] m_inv = merge_bytes({14'h0000, invert_reg}, wr_val, wstrb_reg);
	wire [31:0] m_sel = merge_bytes({14'h0000, buf_sel_reg}, wr_val, wstrb_reg);
	wire [31:0] m_scr = merge_bytes({14'h0000, scramble_reg}, wr_val, wstrb_reg);
	wire [31:0] m_err = merge_bytes({14'h0000, error_reg}, wr_val, wstrb_reg);
	wire wr_inv = do_write & (awaddr_reg == `OFF_LANE_INVERT);
	wire wr_err = do_write & (awaddr_reg == `OFF_LANE_ERROR);
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			run_reg <= 1'b0;
			rot_en_reg <= 1'b0;
			seq_ctrl_reg <= 26'h0000000;
			buf_one_reg <= `BUF_ONE_RESET;
			buf_two_reg <= `BUF_TWO_RESET;
			mask_reg <= `LANE_MASK_RESET;
			invert_reg <= 18'h00000;
			buf_sel_reg <= 18'h00000;
			scramble_reg <= 18'h00000;
			error_reg <= 18'h00000;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				case (awaddr_reg)
					`OFF_SELF_TEST_CONTROL: begin
						run_reg <= m_ctrl[`RUN_BIT];
						rot_en_reg <= m_ctrl[`ROT_EN_BIT];
					end
					`OFF_PATTERN_SEQ_CTRL: seq_ctrl_reg <= m_seq[`SEQ_CTRL_MSB:0];
					`OFF_BUF_ONE_LOW: buf_one_reg[23:0] <= m_b1[`BUF_LOW_MSB:0];
					`OFF_BUF_TWO_LOW: buf_two_reg[23:0] <= m_b2[`BUF_LOW_MSB:0];
					`OFF_BUF_UPPER: begin
						buf_two_reg[39:24] <= m_up[31:16];
						buf_one_reg[39:24] <= m_up[15:0];
					end
					`OFF_LANE_MASK: mask_reg <= m_mask[17:0];
					`OFF_LANE_BUF_TWO: buf_sel_reg <= m_sel[17:0];
					`OFF_LANE_SCRAMBLE: scramble_reg <= m_scr[17:0];
					default: ;
				endcase
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			// A software write wins over rotation in the same cycle
			if (wr_inv)
				invert_reg <= m_inv[17:0];
			else if (rotate_now)
				invert_reg <= {invert_reg[16:0], invert_reg[17]};
			// New failures win over a clearing write
			error_reg <= (wr_err ? m_err[17:0] & error_reg : error_reg) | rx_fail;
		end
	end

endmodule // link_bist_engine

// ### link_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Far end of the link
// ----------------------------------------
module link_partner (
	// Frame control from the bench
	input wire frame_on,
	input wire [17:0] rx_value,
	// Link pins
	output reg link_clk,
	output wire [17:0] rx_lane
);
	// Same width both ends, no lane select: no rotation or scramble limits apply
	assign rx_lane = rx_value;
	// Clock stands low between frames; odd start offset keeps it unrelated to aclk
	initial begin
		link_clk = 1'b0;
		#3;
		forever begin
			if (frame_on) begin
				#40 link_clk = 1'b1;
				#40 link_clk = 1'b0;
			end else begin
				#10;
			end
		end
	end
endmodule // link_partner

// ### link_bist_engine_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module link_bist_checks (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	// Register bus
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Link
	input wire link_clk,
	input wire [17:0] rx_lane,
	input wire [17:0] tx_lane,
	input wire engine_active
);
	reg [7:0] rd_addr;
	wire lane_rd;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Address of the read being answered
	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_addr <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
		end
	end
	assign lane_rd = (rd_addr == 8'h0C) || (rd_addr == 8'h10) || (rd_addr == 8'h18) ||
		(rd_addr == 8'h20) || (rd_addr == 8'h24);
	AST_RESET_IDLE:
	assert property (!$past(aresetn) |-> tx_lane == 18'h00000 && !engine_active && !s_axi_rvalid)
		else $error("outputs not idle after reset");
	AST_IDLE_QUIET:
	assert property (!engine_active && !$past(engine_active) |-> tx_lane == 18'h00000)
		else $error("lanes driven while idle");
	AST_SEQ_FIELDS:
	assert property (s_axi_rvalid && rd_addr == 8'h04 |-> s_axi_rdata[31:26] == 6'h00)
		else $error("sequence reserved bits set");
	AST_BUF_FIELDS:
	assert property (s_axi_rvalid && (rd_addr == 8'h08 || rd_addr == 8'h14)
		|-> s_axi_rdata[31:24] == 8'h00) else $error("buffer reserved bits set");
	AST_LANE_FIELDS:
	assert property (s_axi_rvalid && lane_rd |-> s_axi_rdata[31:18] == 14'h0000)
		else $error("lane register reserved bits set");
	AST_WIDTH_RO:
	assert property (s_axi_rvalid && rd_addr == 8'h00 |-> s_axi_rdata[31])
		else $error("width bit not set");
	AST_READ_ONE:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer not retired");
	AST_WRITE_ANSWER:
	assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write answer late");
	C_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	C_RUN: cover property (engine_active && tx_lane != 18'h00000);
	C_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule // link_bist_checks

bind link_bist_engine link_bist_checks chk_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .rx_lane, .tx_lane,
	.engine_active);

// ### testbench.sv
`timescale 1ns/10ps
`include "link_bist_map.vh"
module testbench;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg frame_on, clk_en;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rd;
	reg [17:0] rx_value, m_mask, m_inv, m_sel, m_scr;
	reg [1:0] resp;
	reg [39:0] b1, b2;
	reg [5:0] ord [0:5];
	reg q1 [$];
	reg q2 [$];
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire link_clk, engine_active;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [17:0] rx_lane, tx_lane;
	integer n_mismatch, checks_done, i, k;
	link_bist_engine dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk,
		.rx_lane, .tx_lane, .engine_active);
	link_partner far_u (.frame_on, .rx_value, .link_clk, .rx_lane);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string what, input [31:0] e, input [31:0] s);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value %0s expected %h seen %h", what, e, s);
			end
		end
	endtask
	// ----------------------------------------
	// Bus tasks; bready and rready stay high
	// ----------------------------------------
	task wr(input [7:0] a, input [31:0] d);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_bvalid !== 1'b1);
			resp = s_axi_bresp;
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (s_axi_rvalid !== 1'b1);
			chk("read data", e, s_axi_rdata);
			chk("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
		end
	endtask
	// ----------------------------------------
	// Reference stream for one loop
	// ----------------------------------------
	task cfg(input [31:0] seq, input [17:0] mk, input [17:0] iv, input [17:0] sl);
		integer s, j;
		reg [1:0] src;
		reg [23:0] tp;
		begin
			m_mask = mk;
			m_inv = iv;
			m_sel = sl;
			wr(`OFF_PATTERN_SEQ_CTRL, seq);
			wr(`OFF_LANE_MASK, {14'h0, mk});
			wr(`OFF_LANE_INVERT, {14'h0, iv});
			wr(`OFF_LANE_BUF_TWO, {14'h0, sl});
			case (seq[12:10])
				3'h1: tp = 24'hAAAAAA;
				3'h2: tp = 24'hCCCCCC;
				3'h3: tp = 24'hE38E38;
				3'h4: tp = 24'hF0F0F0;
				3'h6: tp = 24'hFFF000;
				default: tp = 24'h000000;
			endcase
			q1 = {};
			q2 = {};
			for (s = 0; s < 3; s++) begin
				src = ord[seq[2:0]][2 * s +: 2];
				for (j = 0; j < seq[9:3] * 40 && src == `SRC_BUF; j++) begin
					q1.push_back(b1[j % 40]);
					q2.push_back(b2[j % 40]);
				end
				for (j = 0; j < seq[19:13] * 24 && src == `SRC_TOG && tp != 0; j++) begin
					q1.push_back(tp[j % 24]);
					q2.push_back(tp[j % 24]);
				end
				for (j = 0; j < seq[25:21] * 24 && src == `SRC_CONST; j++) begin
					q1.push_back(seq[20]);
					q2.push_back(seq[20]);
				end
			end
		end
	endtask
	// Sample each bit six aclk after the link edge, well clear of the sync delay
	task run_chk(input rot, input integer nb);
		integer n;
		reg [17:0] e, inv;
		reg [14:0] lf;
		begin
			inv = m_inv;
			lf = `LFSR_SEED;
			wr(`OFF_SELF_TEST_CONTROL, {26'h0, rot, 5'h01});
			frame_on <= 1'b1;
			for (n = 0; n < nb; n++) begin
				if (n > 0 && n % q1.size() == 0 && rot) inv = {inv[16:0], inv[17]};
				@(posedge link_clk);
				repeat (6) @(posedge aclk);
				#1;
				e = ({18{q2[n % q1.size()]}} & m_sel) | ({18{q1[n % q1.size()]}} & ~m_sel);
				e = m_mask & (e ^ inv);
				// Lane i scrambles with shift register bit i mod 15
				e = e ^ (m_scr & {lf[2:0], lf});
				lf = {lf[13:0], lf[14] ^ lf[13]};
				chk("tx lanes", {14'h0, e}, {14'h0, tx_lane});
			end
			chk("engine active", 32'h1, {31'h0, engine_active});
			frame_on <= 1'b0;
			repeat (20) @(posedge aclk);
			wr(`OFF_SELF_TEST_CONTROL, 32'h0);
		end
	endtask
	function [31:0] wmask(input integer r);
		case (r)
			1: wmask = 32'h03FFFFFF;
			2, 5: wmask = 32'h00FFFFFF;
			3, 4, 6, 8: wmask = 32'h0003FFFF;
			7: wmask = 32'hFFFFFFFF;
			default: wmask = 32'h00000000;
		endcase
	endfunction
	initial begin
		#600000;
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, frame_on} = 5'h00;
		{s_axi_bready, s_axi_rready, clk_en} = 3'h7;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_value, m_scr} = 84'h0;
		{n_mismatch, checks_done} = 64'h0;
		ord = '{6'h24, 6'h18, 6'h21, 6'h09, 6'h12, 6'h06};
		b1 = 40'hC35A960F1E;
		b2 = 40'h1EF00FA5C3;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 11; i++) begin
			rchk(8'(4 * i), i == 0 ? 32'h80000000 : (i == 3 ? 32'h3FFFF : 0), i == 10 ? 2 : 0);
		end
		for (i = 1; i < 11; i++) begin
			wr(8'(4 * i), 32'hFFFFFFFF);
			chk("write resp", i == 10 ? 2 : 0, {30'h0, resp});
			rchk(8'(4 * i), wmask(i), i == 10 ? 2 : 0);
		end
		wr(`OFF_LANE_SCRAMBLE, 32'h0);
		wr(`OFF_BUF_ONE_LOW, {8'h00, b1[23:0]});
		wr(`OFF_BUF_TWO_LOW, {8'h00, b2[23:0]});
		wr(`OFF_BUF_UPPER, {b2[39:24], b1[39:24]});
		cfg(32'h10, 18'h3FFF7, 18'h00004, 18'h00002);
		run_chk(1'b0, 120);
		for (k = 1; k < 7; k++) begin
			cfg(32'h2008 | (k << 10), 18'h3FFFF, 18'h0, 18'h0);
			run_chk(1'b0, 128);
		end
		for (k = 0; k < 6; k++) begin
			cfg(32'h302408 | k, 18'h3FFFF, 18'h0, 18'h0);
			run_chk(1'b0, 100);
		end
		cfg(32'h3E00000, 18'h3FFFF, 18'h00001, 18'h0);
		run_chk(1'b1, 800);
		cfg(32'h200000, 18'h3FF7F, 18'h00004, 18'h0);
		// Lane 7 masked yet scrambled; lane 0 fails on the first scrambled one
		m_scr = 18'h00081;
		wr(`OFF_LANE_SCRAMBLE, {14'h0, m_scr});
		wr(`OFF_LANE_ERROR, 32'h0);
		rx_value <= 18'h000A4;
		run_chk(1'b0, 30);
		rchk(`OFF_LANE_ERROR, 32'h21, 2'h0);
		wr(`OFF_LANE_ERROR, 32'h0);
		rchk(`OFF_LANE_ERROR, 32'h0, 2'h0);
		// A low enable must leave a pending read untaken
		clk_en <= 1'b0;
		s_axi_araddr <= `OFF_LANE_MASK;
		s_axi_arvalid <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("frozen read", 32'h1, {31'h0, s_axi_arready & ~s_axi_rvalid});
		clk_en <= 1'b1;
		rchk(`OFF_LANE_MASK, 32'h3FF7F, 2'h0);
		// Reset acts with the enable low
		{aresetn, clk_en} <= 2'h0;
		repeat (3) @(posedge aclk);
		{aresetn, clk_en} <= 2'h3;
		@(posedge aclk);
		rchk(`OFF_LANE_MASK, 32'h3FFFF, 2'h0);
		rchk(`OFF_LANE_SCRAMBLE, 32'h0, 2'h0);
		give_verdict;
	end
endmodule // testbench
